// [dual_joystick_port.v]
// dual joystick port: i/o decode, status register, timer discharge, config mirror
//
// Contract
// - one read-only 8-bit status register sits at base plus zero and is 00h after reset.
// - bits 0..3 are x/y timer outputs of stick one then two, bits 4..7 their buttons.
// - a host write to the port stores nothing but discharges all rc timing pins.
// - the discharge happens when the write strobe falls back to idle, not when it rises.
// - a host i/o read at the programmed base raises the read strobe.
// - a host i/o write at the programmed base raises the write strobe.
// - power control bit 2 and the activate bit are one bit seen at two places.
// - while not activated the base address is not decoded at all.
// - the 16-bit base sits in config bytes 60h (high) and 61h (low).
// - after the discharge each axis bit is high while timing and falls at threshold.
`timescale 1ns/1ps
`default_nettype none
`include "stick_port_consts.vh"
module dual_joystick_port
(
    // clock, reset, enable
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    // host i/o cycle, strobes active high and may stand for several cycles
    input wire [15:0] io_addr,
    input wire io_read,
    input wire io_write,
    output reg [7:0] io_rdata,
    output wire io_hit,
    // configuration port
    input wire [7:0] cfg_index,
    input wire [7:0] cfg_wdata,
    input wire cfg_write,
    output reg [7:0] cfg_rdata,
    // decoded strobes
    output wire stick_read_strobe,
    output wire stick_write_strobe,
    // joystick pins
    input wire stick_one_x_timer_out,
    input wire stick_one_y_timer_out,
    input wire stick_two_x_timer_out,
    input wire stick_two_y_timer_out,
    input wire stick_one_button_one,
    input wire stick_one_button_two,
    input wire stick_two_button_one,
    input wire stick_two_button_two,
    output reg rc_timing_pins
);
    // configuration bytes and their next values
    reg [15:0] base_reg;
    reg [15:0] base_next;
    reg activate_reg;
    reg activate_next;
    // next values of the two readback bytes
    reg [7:0] rdata_next;
    reg [7:0] cfg_rdata_next;
    // trailing-edge detect of the write strobe
    reg write_held_reg;
    reg write_held_next;
    reg rc_pulse_next;
    // pins before and after the synchroniser
    wire [7:0] pins_raw;
    wire [7:0] pins_sync;
    // host address decode
    wire [16:0] addr_sum;
    wire [15:0] status_addr;
    wire addr_match;
    wire decode;
    // configuration index decode
    wire cfg_hit_high;
    wire cfg_hit_low;
    wire cfg_hit_activate;
    wire cfg_hit_power;

    // pin order matches the status byte layout
    assign pins_raw[`BIT_S1_X] = stick_one_x_timer_out;
    assign pins_raw[`BIT_S1_Y] = stick_one_y_timer_out;
    assign pins_raw[`BIT_S2_X] = stick_two_x_timer_out;
    assign pins_raw[`BIT_S2_Y] = stick_two_y_timer_out;
    assign pins_raw[`BIT_S1_B1] = stick_one_button_one;
    assign pins_raw[`BIT_S1_B2] = stick_one_button_two;
    assign pins_raw[`BIT_S2_B1] = stick_two_button_one;
    assign pins_raw[`BIT_S2_B2] = stick_two_button_two;

    // pins are asynchronous; two flops each before anything reads them
    pin_sync u_sync
    (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pin_in(pins_raw),
        .pin_out(pins_sync)
    );

    // status register address; the sum wraps at 64k on purpose, as host i/o does
    assign addr_sum = {1'b0, base_reg} + {1'b0, `STATUS_OFFSET};
    assign status_addr = addr_sum[15:0];
    assign addr_match = (io_addr == status_addr);

    // nothing decodes while the device is off, not even the read strobe
    assign decode = activate_reg && addr_match;
    // clk_en in the strobes so a frozen cycle is never taken as a host access
    assign stick_read_strobe = decode && io_read && clk_en;
    assign stick_write_strobe = decode && io_write && clk_en;
    assign io_hit = stick_read_strobe | stick_write_strobe;

    // configuration index decode
    assign cfg_hit_high = (cfg_index == `BASE_HIGH_INDEX);
    assign cfg_hit_low = (cfg_index == `BASE_LOW_INDEX);
    assign cfg_hit_activate = (cfg_index == `ACTIVATE_INDEX);
    assign cfg_hit_power = (cfg_index == `POWER_CTRL_INDEX);

    // next config state; activate and power bit share one flop so they never disagree
    always @*
    begin
        base_next = base_reg;
        activate_next = activate_reg;
        if (cfg_write)
        begin
            if (cfg_hit_high)
            begin
                base_next[15:8] = cfg_wdata;
            end
            if (cfg_hit_low)
            begin
                base_next[7:0] = cfg_wdata;
            end
            if (cfg_hit_activate)
            begin
                activate_next = cfg_wdata[`ACTIVATE_BIT];
            end
            if (cfg_hit_power)
            begin
                activate_next = cfg_wdata[`POWER_STICK_BIT];
            end
        end
    end

    // readback includes a write of this cycle, so a written byte reads back at once
    always @*
    begin
        cfg_rdata_next = 8'h00;
        case (cfg_index)
            `BASE_HIGH_INDEX: cfg_rdata_next = base_next[15:8];
            `BASE_LOW_INDEX: cfg_rdata_next = base_next[7:0];
            `ACTIVATE_INDEX: cfg_rdata_next[`ACTIVATE_BIT] = activate_next;
            `POWER_CTRL_INDEX: cfg_rdata_next[`POWER_STICK_BIT] = activate_next;
            default: cfg_rdata_next = 8'h00;
        endcase
    end

    // status byte: fresh sample on a decoded read, held between reads
    always @*
    begin
        rdata_next = io_rdata;
        if (stick_read_strobe)
        begin
            rdata_next = pins_sync;
        end
    end

    // strobe stood last cycle and is gone now: that is the back edge
    // a long write gives a single discharge, at its end, never at its start
    always @*
    begin
        write_held_next = stick_write_strobe;
        rc_pulse_next = write_held_reg && !stick_write_strobe;
    end

    // config flops; clk_en low freezes them with the rest
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            base_reg <= `BASE_RESET;
            activate_reg <= `ACTIVATE_RESET;
        end
        else if (clk_en)
        begin
            base_reg <= base_next;
            activate_reg <= activate_next;
        end
    end

    // registered config readback, data outputs come from flops
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            cfg_rdata <= `CFG_RDATA_RESET;
        end
        else if (clk_en)
        begin
            cfg_rdata <= cfg_rdata_next;
        end
    end

    // status register; host writes never reach it
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            io_rdata <= `STATUS_RESET;
        end
        else if (clk_en)
        begin
            io_rdata <= rdata_next;
        end
    end

    // discharge pulse, one cycle long; write data is dropped
    always @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            write_held_reg <= 1'b0;
            rc_timing_pins <= 1'b0;
        end
        else if (clk_en)
        begin
            write_held_reg <= write_held_next;
            rc_timing_pins <= rc_pulse_next;
        end
    end
    // the external timers restart off rc_timing_pins; axis bits then fall at threshold
    // limitation: pin changes reach the status byte three cycles late, two in the synchroniser and one in the status flop
endmodule
`default_nettype wire

// [dual_joystick_port_tb_top.sv]
// testbench for the dual joystick port
`timescale 1ns/1ps
`default_nettype none
module dual_joystick_port_tb_top;
    logic sys_clk = 0, sys_rst = 1, io_read = 0, io_write = 0, cfg_write = 0, clk_en = 1;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0] cfg_index = 8'h00, cfg_wdata = 8'h00, io_rdata, cfg_rdata;
    logic [3:0] btn = 4'ha;
    wire [7:0] pins;
    wire rd_s, wr_s, io_hit, rc;
    int num_errors = 0, cmp_count = 0, cyc = 0;
    dual_joystick_port dual_joystick_port_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .io_addr(io_addr), .io_read(io_read), .io_write(io_write), .io_rdata(io_rdata),
        .io_hit(io_hit), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_write(cfg_write),
        .cfg_rdata(cfg_rdata), .stick_read_strobe(rd_s), .stick_write_strobe(wr_s),
        .stick_one_x_timer_out(pins[0]), .stick_one_y_timer_out(pins[1]),
        .stick_two_x_timer_out(pins[2]), .stick_two_y_timer_out(pins[3]),
        .stick_one_button_one(pins[4]), .stick_one_button_two(pins[5]),
        .stick_two_button_one(pins[6]), .stick_two_button_two(pins[7]), .rc_timing_pins(rc));
    joy_pair joy_pair_i (.sys_clk(sys_clk), .rc_timing_pins(rc), .btn(btn), .pins(pins));
    initial forever #2 sys_clk = ~sys_clk;
    task chk(input [7:0] got, input [7:0] exp);
        cmp_count++;
        if (got !== exp)
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        if (got !== exp)
            num_errors++;
    endtask
    // host cycle held n cycles; strobe checked while it stands
    task io(input rd, input wr, input [15:0] a, input int n, input hit);
        @(posedge sys_clk);
        io_addr <= a;
        io_read <= rd;
        io_write <= wr;
        #1 chk({5'h00, io_hit, rd_s, wr_s}, {5'h00, hit, hit & rd, hit & wr});
        repeat (n) @(posedge sys_clk);
        io_read <= 0;
        io_write <= 0;
        #1;
    endtask
    // config access, w low makes it a pure readback
    task cfg(input [7:0] i, input [7:0] d, input w, input [7:0] exp);
        @(posedge sys_clk);
        cfg_index <= i;
        cfg_wdata <= d;
        cfg_write <= w;
        @(posedge sys_clk);
        cfg_write <= 0;
        #1 chk(cfg_rdata, exp);
    endtask
    task give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard, far above the 126 or so cycles needed
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
            num_errors++;
        if (cyc == 3000)
            give_verdict;
    end
    initial
    begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 0;
        io(1, 0, 16'h0000, 1, 0);
        chk(io_rdata, 8'h00);
        $display("test 1 done");
        cfg(8'h60, 8'h12, 1, 8'h12);
        cfg(8'h61, 8'h34, 1, 8'h34);
        cfg(8'h22, 8'h04, 1, 8'h04);
        cfg(8'h30, 8'h00, 0, 8'h01);
        io(0, 1, 16'h1234, 2, 1);
        repeat (6) @(posedge sys_clk);
        io(1, 0, 16'h1234, 1, 1);
        chk(io_rdata, 8'haf);
        repeat (6) @(posedge sys_clk);
        io(1, 0, 16'h1234, 1, 1);
        chk(io_rdata, 8'hae);
        repeat (6) @(posedge sys_clk);
        io(1, 0, 16'h1234, 1, 1);
        chk(io_rdata, 8'hac);
        repeat (40) @(posedge sys_clk);
        btn <= 4'h5;
        repeat (3) @(posedge sys_clk);
        io(1, 0, 16'h1234, 1, 1);
        chk(io_rdata, 8'h50);
        io(1, 0, 16'h1235, 1, 0);
        chk(io_rdata, 8'h50);
        $display("test 2 done");
        @(posedge sys_clk);
        clk_en <= 0;
        io(1, 0, 16'h1234, 1, 0);
        chk(io_rdata, 8'h50);
        io(0, 1, 16'h1234, 1, 0);
        @(posedge sys_clk);
        clk_en <= 1;
        cfg(8'h30, 8'h00, 1, 8'h00);
        cfg(8'h22, 8'h00, 0, 8'h00);
        io(0, 1, 16'h1234, 1, 0);
        $display("test 3 done");
        @(posedge sys_clk);
        sys_rst <= 1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 0;
        cfg(8'h22, 8'h00, 0, 8'h00);
        cfg(8'h60, 8'h00, 0, 8'h00);
        chk(io_rdata, 8'h00);
        io(1, 0, 16'h0000, 1, 0);
        $display("test 4 done");
        give_verdict;
    end
endmodule
`default_nettype wire

// [joy_pair.sv]
// behavioural pair of joysticks with rc timers
`timescale 1ns/1ps
`default_nettype none
module joy_pair
(
    // clock and discharge
    input wire sys_clk,
    input wire rc_timing_pins,
    // buttons in, pins out
    input wire [3:0] btn,
    output wire [7:0] pins
);
    logic [5:0] cnt_reg = 6'h3f;
    // discharge restarts timing; parks at the top so idle axes read low
    always @(posedge sys_clk)
        cnt_reg <= rc_timing_pins ? 6'h00 : cnt_reg + {5'h00, cnt_reg != 6'h3f};
    // axis i stays high for 8*(i+1) cycles, then times out
    assign pins = {btn, cnt_reg < 6'h20, cnt_reg < 6'h18, cnt_reg < 6'h10, cnt_reg < 6'h08};
endmodule
`default_nettype wire

// [pin_sync.v]
// two-flop synchroniser bank for the joystick pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
    // clock, reset, enable
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    // pins
    input wire [7:0] pin_in,
    output wire [7:0] pin_out
);
    reg [7:0] stage1_reg;
    reg [7:0] stage2_reg;
    genvar i;
    // one pair of flops per pin; first stage feeds only the second
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_bit
            always @(posedge sys_clk)
            begin
                if (sys_rst)
                begin
                    stage1_reg[i] <= 1'b0;
                    stage2_reg[i] <= 1'b0;
                end
                else if (clk_en)
                begin
                    stage1_reg[i] <= pin_in[i];
                    stage2_reg[i] <= stage1_reg[i];
                end
            end
        end
    endgenerate
    assign pin_out = stage2_reg;
endmodule
`default_nettype wire

// [stick_port_asserts.sv]
// concurrent checks on the joystick port pins
`timescale 1ns/1ps
`default_nettype none
module stick_port_asserts
(
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // watched ports
    input wire io_read,
    input wire io_write,
    input wire io_hit,
    input wire [7:0] io_rdata,
    input wire stick_read_strobe,
    input wire stick_write_strobe,
    input wire rc_timing_pins,
    // joystick pins
    input wire stick_one_x_timer_out,
    input wire stick_one_y_timer_out,
    input wire stick_two_x_timer_out,
    input wire stick_two_y_timer_out,
    input wire stick_one_button_one,
    input wire stick_one_button_two,
    input wire stick_two_button_one,
    input wire stick_two_button_two
);
    wire [7:0] pin_bus;
    assign pin_bus = {stick_two_button_two, stick_two_button_one, stick_one_button_two,
        stick_one_button_one, stick_two_y_timer_out, stick_two_x_timer_out,
        stick_one_y_timer_out, stick_one_x_timer_out};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // a read returns the pins as they stood before the two sync flops
    property p_rd; stick_read_strobe |=> io_rdata == $past(pin_bus, 3); endproperty
    a_rd: assert property (p_rd) else $error("read data not the pin levels");
    // both strobes share one decode
    property p_wr; io_hit |-> (io_write == stick_write_strobe) && (io_read == stick_read_strobe); endproperty
    a_wr: assert property (p_wr) else $error("read and write decode disagree");
    // discharge follows the trailing edge, never the leading one
    property p_clr; stick_write_strobe ##1 !stick_write_strobe |=> rc_timing_pins; endproperty
    a_clr: assert property (p_clr) else $error("no discharge after write");
    property p_lead; $rose(stick_write_strobe) |=> !rc_timing_pins; endproperty
    a_lead: assert property (p_lead) else $error("discharge on leading edge");
    property p_cause; rc_timing_pins |-> $past(stick_write_strobe, 2); endproperty
    a_cause: assert property (p_cause) else $error("discharge without write");
    property p_one; rc_timing_pins |=> !rc_timing_pins; endproperty
    a_one: assert property (p_one) else $error("discharge pulse too long");
    // status byte only moves on a decoded read
    property p_hold; !stick_read_strobe |=> $stable(io_rdata); endproperty
    a_hold: assert property (p_hold) else $error("status changed without read");
    property p_rst; $fell(sys_rst) |-> io_rdata == 8'h00 && !rc_timing_pins; endproperty
    a_rst: assert property (p_rst) else $error("bad reset value");
    cover property (stick_read_strobe);
    cover property (stick_write_strobe ##1 stick_write_strobe);
    cover property (rc_timing_pins);
endmodule
bind dual_joystick_port stick_port_asserts stick_port_asserts_i (.*);
`default_nettype wire

// [stick_port_consts.vh]
// constants for the dual joystick port
`ifndef STICK_PORT_CONSTS_VH
`define STICK_PORT_CONSTS_VH
`define STATUS_OFFSET 16'h0000
`define STATUS_RESET 8'h00
`define BASE_HIGH_INDEX 8'h60
`define BASE_LOW_INDEX 8'h61
`define ACTIVATE_INDEX 8'h30
`define POWER_CTRL_INDEX 8'h22
`define POWER_STICK_BIT 2
`define ACTIVATE_BIT 0
`define ACTIVATE_RESET 1'b0
`define CFG_RDATA_RESET 8'h00
`define BASE_RESET 16'h0000
`define BIT_S1_X 0
`define BIT_S1_Y 1
`define BIT_S2_X 2
`define BIT_S2_Y 3
`define BIT_S1_B1 4
`define BIT_S1_B2 5
`define BIT_S2_B1 6
`define BIT_S2_B2 7
`endif
